// >>> hdl/bfpc_consts.vh
`ifndef BFPC_CONSTS_VH
`define BFPC_CONSTS_VH

// data path and offset field widths
`define BFPC_DATA_W 18
`define BFPC_OFS_W 9
`define BFPC_OFS_RST 9'h008

// port a address decode
`define BFPC_ADDR_FIFO 3'h0
`define BFPC_ADDR_BYP 3'h1
`define BFPC_ADDR_AB_AE 3'h4
`define BFPC_ADDR_AB_AF 3'h5
`define BFPC_ADDR_BA_AE 3'h6
`define BFPC_ADDR_BA_AF 3'h7
`define BFPC_ADDR_OFS_BIT 2

// fifo depth as address width, 512 words
`define BFPC_DEPTH_AW 9

`endif

// >>> hdl/bfpc_mem.v
`timescale 1ns/10ps
`include "bfpc_consts.vh"

module bfpc_mem #(
  parameter W = `BFPC_DATA_W,
  parameter AW = `BFPC_DEPTH_AW
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_addr,
  input wire [W-1:0] i_wr_data,
  input wire i_rd_en,
  input wire [AW-1:0] i_rd_addr,
  output reg [W-1:0] o_rd_data
);

  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= {W{1'b0}};
    end else if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule // bfpc_mem

// >>> hdl/bfpc_top.v
`timescale 1ns/10ps
`include "bfpc_consts.vh"

// Notes on behaviour
// - port a acts only while selected
// - port a write captures data bus
// - port a drives output register when enabled
// - port a address picks fifo, bypass, offsets
// - port b ignores port a select
// - port b write goes into b-to-a fifo outside bypass
// - port b drives output register when enabled
// - bypass words cross into opposite output register
// - empty, full, almost flags per direction
// - offsets reset to eight
// - almost flags timed by their port clock
// - flags update on current port edge
// - offset held in low nine bits
// - empty and full flag thresholds
// - almost-empty low up to offset n
// - almost-full low from depth minus m
// - fifo read advances, offset read returns register
// - qualifier high freezes output and pointer
// - bypass indicator follows port a on b edge
module bfpc_top #(
  parameter AW = `BFPC_DEPTH_AW
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_port_a_clock,
  input wire i_port_a_select_n,
  input wire i_port_a_direction,
  input wire i_port_a_xfer_qual_n,
  input wire i_port_a_drive_on_n,
  input wire i_port_a_addr_hi,
  input wire i_port_a_addr_mid,
  input wire i_port_a_addr_lo,
  input wire [`BFPC_DATA_W-1:0] i_port_a_data,
  output reg [`BFPC_DATA_W-1:0] o_port_a_data,
  output reg o_port_a_data_oe,
  input wire i_port_b_clock,
  input wire i_port_b_direction,
  input wire i_port_b_xfer_qual_n,
  input wire i_port_b_drive_on_n,
  input wire [`BFPC_DATA_W-1:0] i_port_b_data,
  output reg [`BFPC_DATA_W-1:0] o_port_b_data,
  output reg o_port_b_data_oe,
  output reg o_empty_flag_a_to_b,
  output reg o_almost_empty_a_to_b,
  output reg o_almost_full_a_to_b,
  output reg o_full_flag_a_to_b,
  output reg o_empty_flag_b_to_a,
  output reg o_almost_empty_b_to_a,
  output reg o_almost_full_b_to_a,
  output reg o_full_flag_b_to_a,
  output reg o_bypass_active_portb_n
);

  localparam CW = AW + 1;
  localparam [CW-1:0] FULL_CNT = {1'b1, {AW{1'b0}}};
  localparam [CW-1:0] ONE_CNT = {{AW{1'b0}}, 1'b1};
  localparam [AW-1:0] ONE_PTR = {{(AW-1){1'b0}}, 1'b1};

  // port clock edge detection, clocks arrive as plain synchronous inputs
  reg a_clk_q;
  reg b_clk_q;
  wire a_edge;
  wire b_edge;

  assign a_edge = i_port_a_clock & ~a_clk_q;
  assign b_edge = i_port_b_clock & ~b_clk_q;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
    end else begin
      a_clk_q <= i_port_a_clock;
      b_clk_q <= i_port_b_clock;
    end
  end

  // offset registers
  reg [`BFPC_OFS_W-1:0] ab_almost_empty_offset;
  reg [`BFPC_OFS_W-1:0] ab_almost_full_offset;
  reg [`BFPC_OFS_W-1:0] ba_almost_empty_offset;
  reg [`BFPC_OFS_W-1:0] ba_almost_full_offset;

  // pointers and word counts
  reg [AW-1:0] ab_wptr;
  reg [AW-1:0] ab_rptr;
  reg [AW-1:0] ba_wptr;
  reg [AW-1:0] ba_rptr;
  reg [CW-1:0] ab_count;
  reg [CW-1:0] ba_count;
  reg a_pend;
  reg b_pend;

  wire [2:0] a_addr;
  wire a_sel;
  wire a_wr;
  wire a_rd;
  wire b_wr;
  wire b_rd;
  wire in_bypass;

  assign a_addr = {i_port_a_addr_hi, i_port_a_addr_mid, i_port_a_addr_lo};
  assign a_sel = ~i_port_a_select_n;
  assign a_wr = a_edge & a_sel & ~i_port_a_direction & ~i_port_a_xfer_qual_n;
  assign a_rd = a_edge & a_sel & i_port_a_direction & ~i_port_a_xfer_qual_n;
  // port b has no select term
  assign b_wr = b_edge & ~i_port_b_direction & ~i_port_b_xfer_qual_n;
  assign b_rd = b_edge & i_port_b_direction & ~i_port_b_xfer_qual_n;
  assign in_bypass = ~o_bypass_active_portb_n;

  wire ab_push;
  wire ab_pop;
  wire ba_push;
  wire ba_pop;

  assign ab_push = a_wr & (a_addr == `BFPC_ADDR_FIFO) & (ab_count != FULL_CNT);
  // port b write fills b-to-a fifo outside bypass
  assign ba_push = b_wr & ~in_bypass & (ba_count != FULL_CNT);
  // fifo read only when data present
  assign ba_pop = a_rd & (a_addr == `BFPC_ADDR_FIFO) & (ba_count != {CW{1'b0}});
  assign ab_pop = b_rd & ~in_bypass & (ab_count != {CW{1'b0}});

  wire [`BFPC_DATA_W-1:0] ab_rd_data;
  wire [`BFPC_DATA_W-1:0] ba_rd_data;

  bfpc_mem #(
    .W(`BFPC_DATA_W),
    .AW(AW)
  ) u_mem_ab (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_en(ab_push),
    .i_wr_addr(ab_wptr),
    .i_wr_data(i_port_a_data),
    .i_rd_en(ab_pop),
    .i_rd_addr(ab_rptr),
    .o_rd_data(ab_rd_data)
  );

  bfpc_mem #(
    .W(`BFPC_DATA_W),
    .AW(AW)
  ) u_mem_ba (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_en(ba_push),
    .i_wr_addr(ba_wptr),
    .i_wr_data(i_port_b_data),
    .i_rd_en(ba_pop),
    .i_rd_addr(ba_rptr),
    .o_rd_data(ba_rd_data)
  );

  // counts kept in one domain, never torn
  reg [CW-1:0] next_ab_count;
  reg [CW-1:0] next_ba_count;

  always @* begin
    next_ab_count = ab_count;
    if (ab_push & ~ab_pop) begin
      next_ab_count = ab_count + ONE_CNT;
    end else if (ab_pop & ~ab_push) begin
      next_ab_count = ab_count - ONE_CNT;
    end
    next_ba_count = ba_count;
    if (ba_push & ~ba_pop) begin
      next_ba_count = ba_count + ONE_CNT;
    end else if (ba_pop & ~ba_push) begin
      next_ba_count = ba_count - ONE_CNT;
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ab_wptr <= {AW{1'b0}};
      ab_rptr <= {AW{1'b0}};
      ba_wptr <= {AW{1'b0}};
      ba_rptr <= {AW{1'b0}};
      ab_count <= {CW{1'b0}};
      ba_count <= {CW{1'b0}};
      a_pend <= 1'b0;
      b_pend <= 1'b0;
    end else begin
      if (ab_push) begin
        ab_wptr <= ab_wptr + ONE_PTR;
      end
      if (ab_pop) begin
        ab_rptr <= ab_rptr + ONE_PTR;
      end
      if (ba_push) begin
        ba_wptr <= ba_wptr + ONE_PTR;
      end
      if (ba_pop) begin
        ba_rptr <= ba_rptr + ONE_PTR;
      end
      ab_count <= next_ab_count;
      ba_count <= next_ba_count;
      a_pend <= ba_pop;
      b_pend <= ab_pop;
    end
  end

  // offset register writes
  wire a_ofs_wr;

  assign a_ofs_wr = a_wr & a_addr[`BFPC_ADDR_OFS_BIT];

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ab_almost_empty_offset <= `BFPC_OFS_RST;
      ab_almost_full_offset <= `BFPC_OFS_RST;
      ba_almost_empty_offset <= `BFPC_OFS_RST;
      ba_almost_full_offset <= `BFPC_OFS_RST;
    end else if (a_ofs_wr) begin
      // offset write, only low bits kept
      case (a_addr)
        `BFPC_ADDR_AB_AE: begin
          ab_almost_empty_offset <= i_port_a_data[`BFPC_OFS_W-1:0];
        end
        `BFPC_ADDR_AB_AF: begin
          ab_almost_full_offset <= i_port_a_data[`BFPC_OFS_W-1:0];
        end
        `BFPC_ADDR_BA_AE: begin
          ba_almost_empty_offset <= i_port_a_data[`BFPC_OFS_W-1:0];
        end
        `BFPC_ADDR_BA_AF: begin
          ba_almost_full_offset <= i_port_a_data[`BFPC_OFS_W-1:0];
        end
        default: begin
          ab_almost_empty_offset <= ab_almost_empty_offset;
        end
      endcase
    end
  end

  // offset readback, upper bits read as zero
  reg [`BFPC_OFS_W-1:0] ofs_rd;

  always @* begin
    case (a_addr)
      `BFPC_ADDR_AB_AE: ofs_rd = ab_almost_empty_offset;
      `BFPC_ADDR_AB_AF: ofs_rd = ab_almost_full_offset;
      `BFPC_ADDR_BA_AE: ofs_rd = ba_almost_empty_offset;
      `BFPC_ADDR_BA_AF: ofs_rd = ba_almost_full_offset;
      default: ofs_rd = {`BFPC_OFS_W{1'b0}};
    endcase
  end

  // port a output register
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_port_a_data <= {`BFPC_DATA_W{1'b0}};
    end else if (a_pend) begin
      // fifo word lands one cycle after the pop
      o_port_a_data <= ba_rd_data;
    end else if (b_wr & in_bypass) begin
      o_port_a_data <= i_port_b_data;
    end else if (a_rd & a_addr[`BFPC_ADDR_OFS_BIT]) begin
      o_port_a_data <= {{(`BFPC_DATA_W-`BFPC_OFS_W){1'b0}}, ofs_rd};
    end
  end

  // port b output register
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_port_b_data <= {`BFPC_DATA_W{1'b0}};
    end else if (b_pend) begin
      o_port_b_data <= ab_rd_data;
    end else if (a_wr & (a_addr == `BFPC_ADDR_BYP)) begin
      o_port_b_data <= i_port_a_data;
    end
  end

  // output enables, one cycle behind the pins
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_port_a_data_oe <= 1'b0;
      o_port_b_data_oe <= 1'b0;
    end else begin
      o_port_a_data_oe <= a_sel & i_port_a_direction & ~i_port_a_drive_on_n;
      o_port_b_data_oe <= i_port_b_direction & ~i_port_b_drive_on_n;
    end
  end

  // bypass indicator taken on port b edge
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_bypass_active_portb_n <= 1'b1;
    end else if (b_edge) begin
      o_bypass_active_portb_n <= ~(a_sel & (a_addr == `BFPC_ADDR_BYP));
    end
  end

  // flag thresholds on the count after this edge
  // compare width covers count plus offset for any depth, shallow or deep
  localparam XW = ((CW > `BFPC_OFS_W) ? CW : `BFPC_OFS_W) + 1;
  wire [XW-1:0] ab_cnt_x;
  wire [XW-1:0] ba_cnt_x;
  wire [XW-1:0] full_x;
  wire [XW-1:0] ab_ae_x;
  wire [XW-1:0] ab_af_x;
  wire [XW-1:0] ba_ae_x;
  wire [XW-1:0] ba_af_x;

  assign ab_cnt_x = {{(XW-CW){1'b0}}, next_ab_count};
  assign ba_cnt_x = {{(XW-CW){1'b0}}, next_ba_count};
  assign full_x = {{(XW-CW){1'b0}}, FULL_CNT};
  assign ab_ae_x = {{(XW-`BFPC_OFS_W){1'b0}}, ab_almost_empty_offset};
  assign ab_af_x = {{(XW-`BFPC_OFS_W){1'b0}}, ab_almost_full_offset};
  assign ba_ae_x = {{(XW-`BFPC_OFS_W){1'b0}}, ba_almost_empty_offset};
  assign ba_af_x = {{(XW-`BFPC_OFS_W){1'b0}}, ba_almost_full_offset};

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_empty_flag_a_to_b <= 1'b0;
      o_almost_empty_a_to_b <= 1'b0;
      o_almost_full_a_to_b <= 1'b1;
      o_full_flag_a_to_b <= 1'b1;
      o_empty_flag_b_to_a <= 1'b0;
      o_almost_empty_b_to_a <= 1'b0;
      o_almost_full_b_to_a <= 1'b1;
      o_full_flag_b_to_a <= 1'b1;
    end else begin
      // a-to-b read side flags on port b edge, current edge
      if (b_edge) begin
        o_empty_flag_a_to_b <= (next_ab_count != {CW{1'b0}});
        o_almost_empty_a_to_b <= (ab_cnt_x > ab_ae_x);
      end
      // a-to-b write side flags on port a edge
      if (a_edge) begin
        o_almost_full_a_to_b <= ((ab_cnt_x + ab_af_x) < full_x);
        o_full_flag_a_to_b <= (next_ab_count != FULL_CNT);
      end
      // b-to-a read side flags on port a edge
      if (a_edge) begin
        o_empty_flag_b_to_a <= (next_ba_count != {CW{1'b0}});
        o_almost_empty_b_to_a <= (ba_cnt_x > ba_ae_x);
      end
      // b-to-a write side flags on port b edge
      if (b_edge) begin
        o_almost_full_b_to_a <= ((ba_cnt_x + ba_af_x) < full_x);
        o_full_flag_b_to_a <= (next_ba_count != FULL_CNT);
      end
    end
  end

endmodule // bfpc_top

// >>> tb/bfpc_top_properties.sv
`timescale 1ns/10ps
module bfpc_props #(
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_port_a_clock,
  input wire i_port_a_select_n,
  input wire i_port_a_direction,
  input wire i_port_a_drive_on_n,
  input wire i_port_a_addr_hi,
  input wire i_port_a_addr_mid,
  input wire i_port_a_addr_lo,
  input wire o_port_a_data_oe,
  input wire i_port_b_clock,
  input wire i_port_b_direction,
  input wire i_port_b_drive_on_n,
  input wire o_port_b_data_oe,
  input wire o_empty_flag_a_to_b,
  input wire o_almost_empty_a_to_b,
  input wire o_almost_full_a_to_b,
  input wire o_full_flag_a_to_b,
  input wire o_bypass_active_portb_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire byp_sel = !i_port_a_select_n && !i_port_a_addr_hi && !i_port_a_addr_mid && i_port_a_addr_lo;
  sel_off_a: assert property (i_port_a_select_n |=> !o_port_a_data_oe)
    else $error("port a driven while off");
  a_drive_a: assert property (!i_port_a_select_n && i_port_a_direction &&
    !i_port_a_drive_on_n |=> o_port_a_data_oe) else $error("port a not driven");
  b_drive_a: assert property (i_port_b_direction && !i_port_b_drive_on_n |=>
    o_port_b_data_oe) else $error("port b not driven");
  empty_ae_a: assert property (!o_empty_flag_a_to_b |-> !o_almost_empty_a_to_b)
    else $error("almost empty high at empty");
  full_af_a: assert property (!o_full_flag_a_to_b |-> !o_almost_full_a_to_b)
    else $error("almost full high at full");
  empty_clk_a: assert property ($changed(o_empty_flag_a_to_b) |->
    $past(i_port_b_clock) || $past(i_port_b_clock, 2)) else $error("empty off its edge");
  full_clk_a: assert property ($changed(o_full_flag_a_to_b) |->
    $past(i_port_a_clock) || $past(i_port_a_clock, 2)) else $error("full off its edge");
  byp_on_a: assert property ($rose(i_port_b_clock) && byp_sel |->
    ##[1:2] !o_bypass_active_portb_n) else $error("bypass flag late");
  cover property ($rose(i_port_b_clock) && byp_sel);
  cover property (!o_full_flag_a_to_b);
  cover property (o_empty_flag_a_to_b && !o_almost_empty_a_to_b);
endmodule // bfpc_props

bind bfpc_top bfpc_props #(.AW(AW)) u_bfpc_props (.*);

// >>> tb/bfpc_proc_b.sv
`timescale 1ns/10ps
module bfpc_proc_b (
  input wire i_clk,
  output reg o_clk,
  output reg o_dir,
  output reg o_qual_n,
  output reg o_drive_n,
  output reg [17:0] o_data
);
  initial begin
    o_clk = 0;
    o_dir = 1;
    o_qual_n = 1;
    o_drive_n = 1;
    o_data = 18'h0_0000;
  end
  // drive request held as a level
  task set_drive(input drive_n);
    begin
      o_drive_n = drive_n;
    end
  endtask
  // one port b clock edge, clock still between
  task b_edge(input en, input dir, input [17:0] d);
    begin
      @(negedge i_clk);
      o_dir = dir;
      o_qual_n = !en;
      o_data = d;
      @(negedge i_clk);
      o_clk = 1;
      @(negedge i_clk);
      o_clk = 0;
      o_qual_n = 1;
      o_data = ~d;
      @(negedge i_clk);
    end
  endtask
endmodule // bfpc_proc_b

// >>> tb/bfpc_top_tb.sv
`timescale 1ns/10ps
module bfpc_top_tb;
  localparam AW = 4;
  localparam D = 16;
  reg i_clk, i_sys_rst, i_port_a_clock, i_port_a_select_n, i_port_a_direction;
  reg i_port_a_xfer_qual_n, i_port_a_drive_on_n, i_port_a_addr_hi, i_port_a_addr_mid;
  reg i_port_a_addr_lo;
  reg [17:0] i_port_a_data;
  wire i_port_b_clock, i_port_b_direction, i_port_b_xfer_qual_n, i_port_b_drive_on_n;
  wire [17:0] i_port_b_data, o_port_a_data, o_port_b_data;
  wire o_port_a_data_oe, o_port_b_data_oe, o_empty_flag_a_to_b, o_almost_empty_a_to_b;
  wire o_almost_full_a_to_b, o_full_flag_a_to_b, o_empty_flag_b_to_a, o_almost_empty_b_to_a;
  wire o_almost_full_b_to_a, o_full_flag_b_to_a, o_bypass_active_portb_n;
  integer miscompares = 0;
  integer checks = 0;
  integer k;
  bfpc_top #(.AW(AW)) u_bfpc_top (.*);
  bfpc_proc_b u_bfpc_proc_b (.i_clk(i_clk), .o_clk(i_port_b_clock), .o_dir(i_port_b_direction),
    .o_qual_n(i_port_b_xfer_qual_n), .o_drive_n(i_port_b_drive_on_n), .o_data(i_port_b_data));
  initial begin
    i_clk = 0;
    forever #10 i_clk = ~i_clk;
  end
  task chk(input string n, input [17:0] s, input [17:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task results;
    begin
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task a_op(input s_n, input dir, input q, input [2:0] ad, input [17:0] d);
    begin
      @(negedge i_clk);
      i_port_a_select_n = s_n;
      i_port_a_direction = dir;
      {i_port_a_addr_hi, i_port_a_addr_mid, i_port_a_addr_lo} = ad;
      i_port_a_xfer_qual_n = q;
      i_port_a_data = d;
      @(negedge i_clk);
      i_port_a_clock = 1;
      @(negedge i_clk);
      i_port_a_clock = 0;
      i_port_a_xfer_qual_n = 1;
      i_port_a_data = ~d;
      @(negedge i_clk);
    end
  endtask
  task t_reset;
    begin
      chk("flags", {o_empty_flag_a_to_b, o_almost_empty_a_to_b, o_almost_full_a_to_b,
        o_full_flag_a_to_b, o_empty_flag_b_to_a, o_almost_empty_b_to_a, o_almost_full_b_to_a,
        o_full_flag_b_to_a}, 8'h33);
      for (k = 4; k < 8; k = k + 1) begin
        a_op(1'b0, 1'b1, 1'b0, k[2:0], 18'h0_0000);
        chk("offset", o_port_a_data, 18'h0_0008);
      end
    end
  endtask
  task t_offset;
    begin
      a_op(1'b0, 1'b0, 1'b0, 3'h4, 18'h3_FE03);
      a_op(1'b0, 1'b1, 1'b0, 3'h4, 18'h0_0000);
      chk("offset wr", o_port_a_data, 18'h0_0003);
    end
  endtask
  task t_desel;
    begin
      a_op(1'b1, 1'b0, 1'b0, 3'h0, 18'h0_0077);
      u_bfpc_proc_b.b_edge(1'b0, 1'b1, 18'h0_0000);
      chk("deselect", o_empty_flag_a_to_b, 1'b0);
    end
  endtask
  task t_ba;
    begin
      // port a still deselected while port b writes
      u_bfpc_proc_b.b_edge(1'b1, 1'b0, 18'h2_AAAA);
      u_bfpc_proc_b.b_edge(1'b1, 1'b0, 18'h1_5555);
      a_op(1'b0, 1'b1, 1'b1, 3'h0, 18'h0_0000);
      chk("held", o_port_a_data, 18'h0_0003);
      chk("ba filled", o_empty_flag_b_to_a, 1'b1);
      a_op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0_0000);
      chk("ba 1", o_port_a_data, 18'h2_AAAA);
      a_op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0_0000);
      chk("ba 2", o_port_a_data, 18'h1_5555);
      chk("ba empty", o_empty_flag_b_to_a, 1'b0);
    end
  endtask
  task t_fill;
    begin
      for (k = 1; k <= D; k = k + 1) begin
        a_op(1'b0, 1'b0, 1'b0, 3'h0, 18'h0_0100 + k[17:0]);
        chk("full", o_full_flag_a_to_b, k != D);
        chk("afull", o_almost_full_a_to_b, k < D - 8);
      end
      a_op(1'b0, 1'b0, 1'b0, 3'h0, 18'h0_0055);
      for (k = 1; k <= D; k = k + 1) begin
        u_bfpc_proc_b.b_edge(1'b1, 1'b1, 18'h0_0000);
        chk("ab word", o_port_b_data, 18'h0_0100 + k[17:0]);
        chk("empty", o_empty_flag_a_to_b, k != D);
        chk("aempty", o_almost_empty_a_to_b, D - k > 3);
      end
      u_bfpc_proc_b.b_edge(1'b1, 1'b1, 18'h0_0000);
      chk("underrun", o_port_b_data, 18'h0_0110);
      for (k = 1; k <= D; k = k + 1) begin
        u_bfpc_proc_b.b_edge(1'b1, 1'b0, 18'h0_0200 + k[17:0]);
        chk("ba full", o_full_flag_b_to_a, k != D);
        chk("ba afull", o_almost_full_b_to_a, k < D - 8);
      end
      for (k = 1; k <= D; k = k + 1) begin
        a_op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0_0000);
        chk("ba word", o_port_a_data, 18'h0_0200 + k[17:0]);
        chk("ba aempty", o_almost_empty_b_to_a, D - k > 8);
      end
    end
  endtask
  task t_bypass;
    begin
      a_op(1'b0, 1'b0, 1'b0, 3'h1, 18'h1_2345);
      chk("byp to b", o_port_b_data, 18'h1_2345);
      u_bfpc_proc_b.b_edge(1'b0, 1'b1, 18'h0_0000);
      chk("byp on", o_bypass_active_portb_n, 1'b0);
      u_bfpc_proc_b.b_edge(1'b1, 1'b0, 18'h2_0ABC);
      chk("byp to a", o_port_a_data, 18'h2_0ABC);
      i_port_a_select_n = 1'b1;
      u_bfpc_proc_b.b_edge(1'b0, 1'b1, 18'h0_0000);
      chk("byp off", o_bypass_active_portb_n, 1'b1);
    end
  endtask
  task t_oe;
    begin
      i_port_a_select_n = 1'b0;
      i_port_a_direction = 1'b1;
      i_port_a_drive_on_n = 1'b0;
      u_bfpc_proc_b.set_drive(1'b0);
      repeat (2) @(negedge i_clk);
      chk("oe on", {o_port_a_data_oe, o_port_b_data_oe}, 2'h3);
      i_port_a_select_n = 1'b1;
      repeat (2) @(negedge i_clk);
      chk("oe off", {o_port_a_data_oe, o_port_b_data_oe}, 2'h1);
    end
  endtask
  initial begin
    i_sys_rst = 1'b1;
    i_port_a_clock = 1'b0;
    i_port_a_drive_on_n = 1'b1;
    i_port_a_select_n = 1'b1;
    i_port_a_direction = 1'b1;
    i_port_a_xfer_qual_n = 1'b1;
    {i_port_a_addr_hi, i_port_a_addr_mid, i_port_a_addr_lo} = 3'h0;
    i_port_a_data = 18'h0_0000;
    repeat (5) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_reset;
    t_offset;
    t_desel;
    t_ba;
    t_fill;
    t_bypass;
    t_oe;
    results;
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    results;
  end
endmodule // bfpc_top_tb
